//--- logic/timer_pkg.sv
package timer_pkg;
   localparam int NUM_CH = 3;
   localparam int CNT_W = 16;
   localparam int CTRL_W = 8;
   // register select codes on the internal bus
   localparam logic [1:0] SEL_CTRL = 2'h0;
   localparam logic [1:0] SEL_REG_A = 2'h1;
   localparam logic [1:0] SEL_REG_B = 2'h2;
   localparam logic [1:0] SEL_COUNT = 2'h3;
   // reset values
   localparam logic [CNT_W-1:0] GEN_RESET = 16'hFFFF;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h80;
   localparam logic [CNT_W-1:0] COUNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] COUNT_ONE = 16'h0001;
   localparam logic [CTRL_W-1:0] CTRL_FIXED = 8'h80;
   // counter control field positions
   localparam int RSV_BIT = 7;
   localparam int CLR_HI = 6;
   localparam int CLR_LO = 5;
   localparam int EDGE_HI = 4;
   localparam int EDGE_LO = 3;
   localparam int SRC_HI = 2;
   localparam int SRC_LO = 0;
   localparam int PHASE_CH = 2;
   // clear select codes
   localparam logic [1:0] CLR_NONE = 2'h0;
   localparam logic [1:0] CLR_ON_A = 2'h1;
   localparam logic [1:0] CLR_ON_B = 2'h2;
   localparam logic [1:0] CLR_SYNC = 2'h3;
   // edge select codes
   localparam logic [1:0] EDGE_RISE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   // capture edge codes (from io control)
   localparam logic [1:0] CAP_RISE = 2'h0;
   localparam logic [1:0] CAP_FALL = 2'h1;
   // prescale divider width
   localparam int DIV_W = 3;

   // bus request from the cpu side
   typedef struct packed {
      logic                 rd;
      logic                 wr;
      logic [1:0]           ch;
      logic [1:0]           sel;
      logic [1:0]           be;   // bit1 upper byte, bit0 lower byte
      logic [CNT_W-1:0]     wdata;
   } bus_req_t;

   // per-channel settings from the neighbouring control logic
   typedef struct packed {
      logic                 capture_a;
      logic                 capture_b;
      logic [1:0]           cap_edge_a;
      logic [1:0]           cap_edge_b;
      logic                 pwm_mode;
      logic                 sync_clear;
   } ch_cfg_t;
endpackage

//--- logic/edge_detect.sv
// registered copy of a level plus rise / fall pulses
module edge_detect
   import timer_pkg::*;
(
   // clock and reset
   input  wire logic mclk,
   input  wire logic resetn,
   // level in, edges out
   input  wire logic level,
   output logic      rise,
   output logic      fall
);
   logic last_q;
   logic last_d;

   // next previous-sample value
   always_comb begin
      last_d = level;
   end

   // sample register
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         last_q <= 1'b0;
      end else begin
         last_q <= last_d;
      end
   end

   // edges against the previous sample
   assign rise = level & ~last_q;
   assign fall = ~level & last_q;
endmodule

//--- logic/timer_core.sv
module timer_core
   import timer_pkg::*;
(
   // clock and reset
   input  wire logic                       mclk,
   input  wire logic                       resetn,
   input  wire logic                       standby,
   // cpu bus
   input  wire bus_req_t                   bus_req,
   output logic [CNT_W-1:0]                rdata_q,
   // external clocks and capture inputs
   input  wire logic [3:0]                 ext_clock,
   input  wire logic [NUM_CH-1:0]          capture_in_a,
   input  wire logic [NUM_CH-1:0]          capture_in_b,
   // neighbouring control settings
   input  wire ch_cfg_t [NUM_CH-1:0]       ch_cfg,
   input  wire logic                       phase_count_enable,
   input  wire logic                       phase_step,
   input  wire logic                       phase_up,
   // events and state
   output logic [NUM_CH-1:0]               match_flag_a_q,
   output logic [NUM_CH-1:0]               match_flag_b_q,
   output logic [NUM_CH-1:0]               count_clear_q,
   output logic [NUM_CH*CNT_W-1:0]         channel_counter_q
);
   // internal prescaler and ext clock edges
   logic [DIV_W-1:0] div_q;
   logic [DIV_W-1:0] div_d;
   logic [3:0]       ext_rise;
   logic [3:0]       ext_fall;
   logic [DIV_W:0]   int_fall;

   // free running divider for internal sources
   always_comb begin
      div_d = div_q + 3'h1;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         div_q <= '0;
      end else begin
         div_q <= div_d;
      end
   end

   // falling edge of phi/2^n: the tick where bits below all wrap
   always_comb begin
      int_fall[0] = 1'b1;
      int_fall[1] = div_q[0];
      int_fall[2] = &div_q[1:0];
      int_fall[3] = &div_q[2:0];
   end

   // external clock edge detectors
   genvar e;
   generate
      for (e = 0; e < 4; e++) begin : g_ext
         edge_detect u_edge (
            .mclk   (mclk),
            .resetn (resetn),
            .level  (ext_clock[e]),
            .rise   (ext_rise[e]),
            .fall   (ext_fall[e])
         );
      end
   endgenerate

   // read mux inputs per channel
   logic [CNT_W-1:0]  ctrl_rd   [NUM_CH];
   logic [CNT_W-1:0]  reg_a_rd  [NUM_CH];
   logic [CNT_W-1:0]  reg_b_rd  [NUM_CH];
   logic [CNT_W-1:0]  count_rd  [NUM_CH];

   genvar c;
   generate
      for (c = 0; c < NUM_CH; c++) begin : g_ch
         logic [CTRL_W-1:0] ctrl_q;
         logic [CTRL_W-1:0] ctrl_d;
         logic [CNT_W-1:0]  reg_a_q;
         logic [CNT_W-1:0]  reg_a_d;
         logic [CNT_W-1:0]  reg_b_q;
         logic [CNT_W-1:0]  reg_b_d;
         logic [CNT_W-1:0]  cnt_q;
         logic [CNT_W-1:0]  cnt_d;
         logic              fa_q;
         logic              fa_d;
         logic              fb_q;
         logic              fb_d;
         logic              clr_q;
         logic              clr_d;
         logic              cap_a_rise;
         logic              cap_a_fall;
         logic              cap_b_rise;
         logic              cap_b_fall;
         logic              use_cap_a;
         logic              use_cap_b;
         logic              hit_a;
         logic              hit_b;
         logic              cap_a;
         logic              cap_b;
         logic              tick;
         logic              cnt_wr;
         logic              phase;
         logic              clear;
         logic              sel_ch;
         logic [1:0]        clr_sel;
         logic [1:0]        edge_sel;
         logic [2:0]        src;

         edge_detect u_cap_a (
            .mclk   (mclk),
            .resetn (resetn),
            .level  (capture_in_a[c]),
            .rise   (cap_a_rise),
            .fall   (cap_a_fall)
         );

         edge_detect u_cap_b (
            .mclk   (mclk),
            .resetn (resetn),
            .level  (capture_in_b[c]),
            .rise   (cap_b_rise),
            .fall   (cap_b_fall)
         );

         // field decode and event sources
         always_comb begin
            sel_ch   = (bus_req.ch == 2'(c));
            clr_sel  = ctrl_q[CLR_HI:CLR_LO];
            edge_sel = ctrl_q[EDGE_HI:EDGE_LO];
            src      = ctrl_q[SRC_HI:SRC_LO];
            // pwm forces compare use of both registers
            use_cap_a = ch_cfg[c].capture_a & ~ch_cfg[c].pwm_mode;
            use_cap_b = ch_cfg[c].capture_b & ~ch_cfg[c].pwm_mode;
            // capture edge selection from io control inputs
            case (ch_cfg[c].cap_edge_a)
               CAP_RISE: cap_a = cap_a_rise;
               CAP_FALL: cap_a = cap_a_fall;
               default:  cap_a = cap_a_rise | cap_a_fall;
            endcase
            case (ch_cfg[c].cap_edge_b)
               CAP_RISE: cap_b = cap_b_rise;
               CAP_FALL: cap_b = cap_b_fall;
               default:  cap_b = cap_b_rise | cap_b_fall;
            endcase
            cap_a = cap_a & use_cap_a;
            cap_b = cap_b & use_cap_b;
            hit_a = ~use_cap_a & (cnt_q == reg_a_q);
            hit_b = ~use_cap_b & (cnt_q == reg_b_q);
            // count source select
            if (src[SRC_HI]) begin
               case (edge_sel)
                  EDGE_RISE: tick = ext_rise[src[1:0]];
                  EDGE_FALL: tick = ext_fall[src[1:0]];
                  default:   tick = ext_rise[src[1:0]] | ext_fall[src[1:0]];
               endcase
            end else begin
               tick = int_fall[src[1:0]];
            end
            phase = (c == PHASE_CH) && phase_count_enable;
            if (phase) begin
               tick = phase_step;
            end
            case (clr_sel)
               CLR_NONE: clear = 1'b0;
               CLR_ON_A: clear = hit_a | cap_a;
               CLR_ON_B: clear = hit_b | cap_b;
               CLR_SYNC: clear = ch_cfg[c].sync_clear;
               default:  clear = 1'b0;
            endcase
         end

         // next register values, bus write then hardware event
         always_comb begin
            ctrl_d  = ctrl_q;
            reg_a_d = reg_a_q;
            reg_b_d = reg_b_q;
            cnt_d   = cnt_q;
            clr_d   = clear;
            // a bus write to the counter wins over a count tick
            cnt_wr  = bus_req.wr && sel_ch && (bus_req.sel == SEL_COUNT)
                      && (|bus_req.be);
            if (bus_req.wr && sel_ch) begin
               case (bus_req.sel)
                  SEL_CTRL: begin
                     if (bus_req.be[0]) begin
                        ctrl_d = bus_req.wdata[CTRL_W-1:0] | CTRL_FIXED;
                     end
                  end
                  SEL_REG_A: begin
                     if (bus_req.be[1]) reg_a_d[15:8] = bus_req.wdata[15:8];
                     if (bus_req.be[0]) reg_a_d[7:0] = bus_req.wdata[7:0];
                  end
                  SEL_REG_B: begin
                     if (bus_req.be[1]) reg_b_d[15:8] = bus_req.wdata[15:8];
                     if (bus_req.be[0]) reg_b_d[7:0] = bus_req.wdata[7:0];
                  end
                  SEL_COUNT: begin
                     if (bus_req.be[1]) cnt_d[15:8] = bus_req.wdata[15:8];
                     if (bus_req.be[0]) cnt_d[7:0] = bus_req.wdata[7:0];
                  end
                  default: ;
               endcase
            end
            if (cap_a) reg_a_d = cnt_q;
            if (cap_b) reg_b_d = cnt_q;
            if (clear) begin
               cnt_d = COUNT_ZERO;
            end else if (tick && !cnt_wr) begin
               if (phase && !phase_up) cnt_d = cnt_q - COUNT_ONE;
               else cnt_d = cnt_q + COUNT_ONE;
            end
            fa_d = hit_a | cap_a;
            fb_d = hit_b | cap_b;
            if (standby) begin
               ctrl_d  = CTRL_RESET;
               reg_a_d = GEN_RESET;
               reg_b_d = GEN_RESET;
               cnt_d   = COUNT_ZERO;
               fa_d    = 1'b0;
               fb_d    = 1'b0;
               clr_d   = 1'b0;
            end
         end

         // channel state registers
         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               ctrl_q  <= CTRL_RESET;
               reg_a_q <= GEN_RESET;
               reg_b_q <= GEN_RESET;
               cnt_q   <= COUNT_ZERO;
               fa_q    <= 1'b0;
               fb_q    <= 1'b0;
               clr_q   <= 1'b0;
            end else begin
               ctrl_q  <= ctrl_d;
               reg_a_q <= reg_a_d;
               reg_b_q <= reg_b_d;
               cnt_q   <= cnt_d;
               fa_q    <= fa_d;
               fb_q    <= fb_d;
               clr_q   <= clr_d;
            end
         end

         // read values and event outputs
         assign ctrl_rd[c]  = {8'h00, ctrl_q | CTRL_FIXED};
         assign reg_a_rd[c] = reg_a_q;
         assign reg_b_rd[c] = reg_b_q;
         assign count_rd[c] = cnt_q;
         assign match_flag_a_q[c] = fa_q;
         assign match_flag_b_q[c] = fb_q;
         assign count_clear_q[c]  = clr_q;
         assign channel_counter_q[c*CNT_W +: CNT_W] = cnt_q;
      end
   endgenerate

   // registered read data, unselected lanes and bad channel read zero
   logic [CNT_W-1:0] rdata_d;
   logic [CNT_W-1:0] word;
   always_comb begin
      word = '0;
      if (bus_req.ch < 2'(NUM_CH)) begin
         case (bus_req.sel)
            SEL_CTRL:  word = ctrl_rd[bus_req.ch];
            SEL_REG_A: word = reg_a_rd[bus_req.ch];
            SEL_REG_B: word = reg_b_rd[bus_req.ch];
            SEL_COUNT: word = count_rd[bus_req.ch];
            default:   word = '0;
         endcase
      end
      rdata_d = rdata_q;
      if (bus_req.rd) begin
         rdata_d = {bus_req.be[1] ? word[15:8] : 8'h00,
                    bus_req.be[0] ? word[7:0] : 8'h00};
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end
endmodule

//--- test/timer_core_props.sv
module timer_core_props
   import timer_pkg::*;
(
   // clock, reset
   input wire logic                     mclk,
   input wire logic                     resetn,
   input wire logic                     standby,
   // bus
   input wire bus_req_t                 bus_req,
   input wire logic [CNT_W-1:0]         rdata_q,
   // pins, settings
   input wire logic [NUM_CH-1:0]        capture_in_a,
   input wire ch_cfg_t [NUM_CH-1:0]     ch_cfg,
   input wire logic                     phase_count_enable,
   input wire logic                     phase_step,
   // events, counters
   input wire logic [NUM_CH-1:0]        match_flag_a_q,
   input wire logic [NUM_CH-1:0]        count_clear_q,
   input wire logic [NUM_CH*CNT_W-1:0]  channel_counter_q
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   // counter slices and bus writes that may move them
   wire logic [CNT_W-1:0] cnt0 = channel_counter_q[CNT_W-1:0];
   wire logic [CNT_W-1:0] cnt2 = channel_counter_q[3*CNT_W-1:2*CNT_W];
   wire logic wr0 = bus_req.wr && bus_req.ch == 2'h0 && bus_req.sel == SEL_COUNT;
   wire logic wr2 = bus_req.wr && bus_req.ch == 2'h2 && bus_req.sel == SEL_COUNT;

   chk_ctrl_top_bit: assert property (
      bus_req.rd && bus_req.sel == SEL_CTRL && bus_req.ch != 2'h3 &&
      bus_req.be[0] && !standby |=> rdata_q[RSV_BIT])
      else $error("control bit 7 read as 0");
   chk_no_fourth_ch: assert property (
      bus_req.rd && bus_req.ch == 2'h3 && !standby |=> rdata_q == COUNT_ZERO)
      else $error("channel 3 read not zero");
   chk_standby_init: assert property (
      standby |=> channel_counter_q == '0 && match_flag_a_q == '0)
      else $error("standby did not initialise");
   chk_count_step: assert property (
      !standby && !wr0 |=> cnt0 == $past(cnt0) ||
      cnt0 == $past(cnt0) + COUNT_ONE || cnt0 == COUNT_ZERO)
      else $error("counter 0 jumped");
   chk_clear_zero: assert property (
      count_clear_q[0] |-> cnt0 == COUNT_ZERO || $past(cnt0) == COUNT_ZERO)
      else $error("clear left counter nonzero");
   chk_capture_flag: assert property (
      ch_cfg[1].capture_a && !ch_cfg[1].pwm_mode && !standby &&
      ch_cfg[1].cap_edge_a == CAP_RISE && $rose(capture_in_a[1])
      |-> ##[1:3] match_flag_a_q[1])
      else $error("capture gave no flag");
   chk_rdata_stands: assert property (
      !bus_req.rd && !standby |=> $stable(rdata_q))
      else $error("read data moved without read");
   chk_phase_hold: assert property (
      (phase_count_enable && !phase_step && !wr2 && !standby) [*3]
      |=> cnt2 == $past(cnt2) || cnt2 == COUNT_ZERO)
      else $error("channel 2 counted outside phase steps");
   // main scenarios reached
   cov_clear: cover property (count_clear_q[0]);
   cov_capture: cover property (match_flag_a_q[1]);
   cov_phase: cover property (phase_count_enable && phase_step);
endmodule

bind timer_core timer_core_props timer_core_props_inst (
   .mclk(mclk), .resetn(resetn), .standby(standby), .bus_req(bus_req),
   .rdata_q(rdata_q), .capture_in_a(capture_in_a), .ch_cfg(ch_cfg),
   .phase_count_enable(phase_count_enable), .phase_step(phase_step),
   .match_flag_a_q(match_flag_a_q), .count_clear_q(count_clear_q),
   .channel_counter_q(channel_counter_q));

//--- test/ext_pins.sv
module ext_pins
   import timer_pkg::*;
(
   // clock
   input  wire logic          mclk,
   // pins toward the timer
   output logic [3:0]         ext_clock,
   output logic [NUM_CH-1:0]  capture_in_a
);
   timeunit 1ns;
   timeprecision 1ps;
   // clocks stand still low between bursts
   initial begin
      ext_clock = 4'h0;
      capture_in_a = '0;
   end
   // n pulses on one line, two cycles high, three low
   task automatic clocks(input int line, input int n);
      repeat (n) begin
         @(posedge mclk) ext_clock[line] <= 1'b1;
         repeat (2) @(posedge mclk);
         ext_clock[line] <= 1'b0;
         repeat (2) @(posedge mclk);
      end
   endtask
   // capture pin level for one channel
   task automatic capture(input int c, input logic lvl);
      @(posedge mclk) capture_in_a[c] <= lvl;
   endtask
endmodule

//--- test/timer_compare_capture_clocking_test.sv
module timer_compare_capture_clocking_test
   import timer_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // design signals
   logic                    mclk = 1'b0;
   logic                    resetn = 1'b0;
   logic                    standby = 1'b0;
   bus_req_t                bus_req = '0;
   ch_cfg_t [NUM_CH-1:0]    ch_cfg = '0;
   logic                    pce = 1'b0;
   logic                    step = 1'b0;
   logic [CNT_W-1:0]        rdata_q, v;
   logic [3:0]              ext_clock;
   logic [NUM_CH-1:0]       cap_a, fa, fb, clr;
   logic [NUM_CH*CNT_W-1:0] cnt;
   int                      num_errors = 0;
   int                      cmp_count = 0;

   always #2.5 mclk = ~mclk;

   timer_core timer_core_inst (.mclk(mclk), .resetn(resetn),
      .standby(standby), .bus_req(bus_req), .rdata_q(rdata_q),
      .ext_clock(ext_clock), .capture_in_a(cap_a), .capture_in_b(3'h0),
      .ch_cfg(ch_cfg), .phase_count_enable(pce), .phase_step(step),
      .phase_up(1'b1), .match_flag_a_q(fa), .match_flag_b_q(fb),
      .count_clear_q(clr), .channel_counter_q(cnt));
   ext_pins ext_pins_inst (.mclk(mclk), .ext_clock(ext_clock),
      .capture_in_a(cap_a));

   // one bus write, taken at the second edge
   task automatic bw(input int c, input logic [1:0] s, b,
                     input logic [15:0] d);
      @(posedge mclk) bus_req <= '{1'b0, 1'b1, 2'(c), s, b, d};
      @(posedge mclk) bus_req.wr <= 1'b0;
   endtask
   // one bus read, data settled after the taking edge
   task automatic br(input int c, input logic [1:0] s, b);
      @(posedge mclk) bus_req <= '{1'b1, 1'b0, 2'(c), s, b, 16'h0000};
      @(posedge mclk) bus_req.rd <= 1'b0;
      #1 v = rdata_q;
   endtask
   // compare against a closed range
   task automatic chk(input string n, input logic [15:0] lo, hi, g);
      cmp_count++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         num_errors++;
         $display("[FAIL] %s expected %h..%h seen %h", n, lo, hi, g);
      end
   endtask
   // collect clear, flag b, flag a events of a channel over 40 cycles
   task automatic watch(input int c, output logic [2:0] ev);
      ev = 3'h0;
      repeat (40) @(posedge mclk) #1 ev = ev | {clr[c], fb[c], fa[c]};
   endtask

   task automatic t_init();
      for (int c = 0; c < NUM_CH; c++) begin
         br(c, SEL_CTRL, 2'h1);
         chk("ctrl init", CTRL_RESET, CTRL_RESET, v);
         br(c, SEL_REG_A, 2'h3);
         chk("reg a init", GEN_RESET, GEN_RESET, v);
         br(c, SEL_REG_B, 2'h3);
         chk("reg b init", GEN_RESET, GEN_RESET, v);
      end
      $display("init done");
   endtask

   task automatic t_access();
      bw(1, SEL_REG_A, 2'h3, 16'h1234);
      bw(1, SEL_REG_A, 2'h2, 16'hAB00);
      br(1, SEL_REG_A, 2'h3);
      chk("word after byte", 16'hAB34, 16'hAB34, v);
      br(1, SEL_REG_A, 2'h1);
      chk("low byte read", 16'h0034, 16'h0034, v);
      bw(0, SEL_REG_B, 2'h1, 16'h0055);
      br(0, SEL_REG_B, 2'h3);
      chk("low byte write", 16'hFF55, 16'hFF55, v);
      bw(2, SEL_CTRL, 2'h3, 16'h007F);
      br(2, SEL_CTRL, 2'h1);
      chk("ctrl bit 7", 16'h00FF, 16'h00FF, v);
      $display("access done");
   endtask

   task automatic t_clear();
      logic [2:0] ev;
      logic [2:0] exp_ev [4] = '{3'h3, 3'h5, 3'h7, 3'h4};
      logic [15:0] hi [4] = '{16'h0040, 16'h0010, 16'h0018, 16'h0001};
      bw(0, SEL_REG_A, 2'h3, 16'h0010);
      bw(0, SEL_REG_B, 2'h3, 16'h0018);
      for (int k = 0; k < 4; k++) begin
         bw(0, SEL_CTRL, 2'h3, 16'(k << CLR_LO));
         bw(0, SEL_COUNT, 2'h3, COUNT_ZERO);
         ch_cfg[0].sync_clear <= (k == 3);
         watch(0, ev);
         chk("clear events", exp_ev[k], exp_ev[k], 16'(ev));
         br(0, SEL_COUNT, 2'h3);
         chk("count after", k ? 16'h0 : 16'h18, hi[k], v);
         ch_cfg[0].sync_clear <= 1'b0;
      end
      $display("clear done");
   endtask

   task automatic t_div();
      for (int s = 0; s < 4; s++) begin
         bw(1, SEL_CTRL, 2'h3, 16'(s));
         bw(1, SEL_COUNT, 2'h3, COUNT_ZERO);
         repeat (32) @(posedge mclk);
         br(1, SEL_COUNT, 2'h3);
         chk("divided", 16'(32 >> s), 16'((34 >> s) + 1), v);
      end
      $display("divide done");
   endtask

   task automatic t_ext();
      logic [15:0] w;
      for (int s = 4; s < 8; s++)
         for (int e = 0; e < 4; e++) begin
            w = (e >= 2) ? 16'h0006 : 16'h0003;
            bw(2, SEL_CTRL, 2'h3, 16'((e << EDGE_LO) | s));
            bw(2, SEL_COUNT, 2'h3, COUNT_ZERO);
            ext_pins_inst.clocks((s - 3) % 4, 2);
            ext_pins_inst.clocks(s - 4, 3);
            repeat (4) @(posedge mclk);
            br(2, SEL_COUNT, 2'h3);
            chk("ext edges", w, w, v);
         end
      $display("external done");
   endtask

   task automatic t_phase();
      pce <= 1'b1;
      bw(2, SEL_CTRL, 2'h3, 16'h0004);
      bw(2, SEL_COUNT, 2'h3, COUNT_ZERO);
      ext_pins_inst.clocks(0, 3);
      br(2, SEL_COUNT, 2'h3);
      chk("phase ignores clk", 16'h0, 16'h0, v);
      repeat (2) begin
         @(posedge mclk) step <= 1'b1;
         @(posedge mclk) step <= 1'b0;
      end
      repeat (3) @(posedge mclk);
      br(2, SEL_COUNT, 2'h3);
      chk("phase steps", 16'h2, 16'h2, v);
      pce <= 1'b0;
      $display("phase done");
   endtask

   task automatic t_capture();
      logic [2:0] ev;
      bw(1, SEL_CTRL, 2'h3, 16'h0020);
      ch_cfg[1].capture_a <= 1'b1;
      bw(1, SEL_COUNT, 2'h3, 16'h0100);
      ext_pins_inst.capture(1, 1'b1);
      watch(1, ev);
      chk("capture events", 16'h5, 16'h5, 16'(ev));
      br(1, SEL_REG_A, 2'h3);
      chk("captured", 16'h0100, 16'h0108, v);
      ch_cfg[1].cap_edge_a <= CAP_FALL;
      bw(1, SEL_COUNT, 2'h3, 16'h0200);
      ext_pins_inst.capture(1, 1'b0);
      watch(1, ev);
      chk("fall capture events", 16'h5, 16'h5, 16'(ev));
      br(1, SEL_REG_A, 2'h3);
      chk("fall captured", 16'h0200, 16'h0208, v);
      ch_cfg[1].cap_edge_a <= CAP_RISE;
      ch_cfg[1].pwm_mode <= 1'b1;
      bw(1, SEL_REG_A, 2'h3, 16'hFFF0);
      ext_pins_inst.capture(1, 1'b0);
      ext_pins_inst.capture(1, 1'b1);
      watch(1, ev);
      chk("pwm events", 16'h0, 16'h0, 16'(ev));
      br(1, SEL_REG_A, 2'h3);
      chk("pwm no capture", 16'hFFF0, 16'hFFF0, v);
      ch_cfg[1] <= '0;
      $display("capture done");
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (5) @(posedge mclk);
      resetn <= 1'b1;
      t_init();
      t_access();
      t_clear();
      t_div();
      t_ext();
      t_phase();
      t_capture();
      @(posedge mclk) standby <= 1'b1;
      @(posedge mclk) standby <= 1'b0;
      t_init();
      summarize();
   end
   // hang guard
   initial begin
      repeat (8000) @(posedge mclk);
      num_errors++;
      summarize();
   end
endmodule
